// ### gdrv_cfg_pkg.sv
`default_nettype none
package gdrv_cfg_pkg;
    // register offsets (5-bit address field)
    localparam logic [4:0] OFS_PRECHG = 5'h08;
    localparam logic [4:0] OFS_DIAG = 5'h09;
    localparam logic [4:0] OFS_STICHG = 5'h0a;
    // reset values
    localparam logic [15:0] RST_PRECHG = 16'h0000;
    localparam logic [15:0] RST_DIAG = 16'hc000;
    localparam logic [15:0] RST_STICHG = 16'h0044;
    // writable masks; reserved diag and static bits are read-only and read zero, precharge stores all 16 bits
    localparam logic [15:0] WMASK_PRECHG = 16'hffff;
    localparam logic [15:0] WMASK_DIAG = 16'hff0f;
    localparam logic [15:0] WMASK_STICHG = 16'h0fff;
    // field positions
    localparam int POS_DEEP_AD = 14;
    localparam int POS_GEN_DET = 12;
    localparam int POS_CSA_SIDE = 14;
    localparam int POS_OCFILT = 10;
    localparam int POS_CSA_OFF = 8;
    localparam int POS_STSEL = 8;
    localparam int POS_SET2 = 4;
    localparam int POS_SET1 = 0;
    // timing: base step 125 ns, filter times in ns
    localparam int CLK_PERIOD_NS = 10;
    localparam int TSTEP_NS = 125;
    localparam int TSTEP_CYC = (TSTEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OCF_NS0 = 6000;
    localparam int OCF_NS1 = 10000;
    localparam int OCF_NS2 = 50000;
    localparam int OCF_NS3 = 100000;
    localparam int OCF_CYC0 = OCF_NS0 / CLK_PERIOD_NS;
    localparam int OCF_CYC1 = OCF_NS1 / CLK_PERIOD_NS;
    localparam int OCF_CYC2 = OCF_NS2 / CLK_PERIOD_NS;
    localparam int OCF_CYC3 = OCF_NS3 / CLK_PERIOD_NS;
    // register bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic bank;
        logic [4:0] addr;
        logic [15:0] wdata;
    } reg_req_t;
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} tmr_state_t;
endpackage
`default_nettype wire

// ### gdrv_phase_timer.sv
`default_nettype none
// one-shot timer of (2^code)*step cycles, code 0..3
module gdrv_phase_timer
    import gdrv_cfg_pkg::*;
#(
    parameter int STEP_CYC = TSTEP_CYC
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_start,
    input wire logic [1:0] i_code,
    output logic o_busy,
    output logic o_done
);
    localparam int CW = $clog2(STEP_CYC * 8 + 1);
    if (STEP_CYC < 1) begin : g_bad_step
        $error("step must be at least one cycle");
    end
    tmr_state_t st_q, st_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic done_q, done_d;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        done_d = 1'b0;
        case (st_q)
            ST_IDLE: begin
                if (i_start) begin
                    // count of 1/2/4/8 steps, each 125 ns rounded up to whole cycles, less one
                    cnt_d = CW'(STEP_CYC << i_code) - CW'(1);
                    st_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (cnt_q == '0) begin
                    done_d = 1'b1;
                    st_d = ST_DONE;
                end else begin
                    cnt_d = cnt_q - CW'(1);
                end
            end
            ST_DONE: st_d = ST_IDLE;
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_q <= ST_IDLE;
            cnt_q <= '0;
            done_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            done_q <= done_d;
        end
    end
    assign o_busy = (st_q == ST_RUN);
    assign o_done = done_q;
endmodule // gdrv_phase_timer
`default_nettype wire

// ### gdrv_cfg_regs.sv
`default_nettype none
module gdrv_cfg_regs
    import gdrv_cfg_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // register access from the serial interface logic
    input wire reg_req_t i_req,
    output logic [15:0] o_rdata,
    output logic o_rvalid,
    // pwm phase requests, per channel, same clock
    input wire logic [2:0] i_prechg_start,
    input wire logic [2:0] i_predchg_start,
    // pwm phase activity, per channel
    output logic [2:0] o_prechg_active,
    output logic [2:0] o_predchg_active,
    // gate drive controls
    output logic o_deep_adapt_en,
    output logic o_generator_detect_enable,
    output logic o_sense_amp_side_select,
    output logic [1:0] o_overcurrent_filter_time,
    output logic [16:0] o_oc_filter_cycles,
    output logic o_sense_amp_disable,
    output logic [3:0] o_bridge_offstate_pulldown,
    output logic [3:0] o_bridge_static_set_select,
    output logic [3:0] o_static_gate_current_set1,
    output logic [3:0] o_static_gate_current_set2,
    output logic [15:0] o_pwm_precharge_timing
);
    logic [15:0] prechg_q, prechg_d;
    logic [15:0] diag_q, diag_d;
    logic [15:0] stichg_q, stichg_d;
    logic [15:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic [2:0] pc_busy, pc_done, pd_busy, pd_done;
    logic [2:0] pc_act_q, pd_act_q;

    function automatic logic [1:0] chan_code(input logic [15:0] r, input int ch, input bit dis);
        chan_code = r[ch*4 + (dis ? 2 : 0) +: 2];
    endfunction

    function automatic logic [16:0] ocf_cycles(input logic [1:0] c);
        case (c)
            2'b00: ocf_cycles = 17'(OCF_CYC0);
            2'b01: ocf_cycles = 17'(OCF_CYC1);
            2'b10: ocf_cycles = 17'(OCF_CYC2);
            default: ocf_cycles = 17'(OCF_CYC3);
        endcase
    endfunction

    // bank-qualified decode; the other two offsets are bank independent here
    function automatic logic hit(input reg_req_t r, input logic [4:0] ofs);
        hit = (r.addr == ofs) && ((ofs != OFS_STICHG) || !r.bank);
    endfunction

    always_comb begin
        prechg_d = prechg_q;
        diag_d = diag_q;
        stichg_d = stichg_q;
        rvalid_d = i_req.rd;
        rdata_d = rdata_q;
        if (i_req.wr) begin
            // reserved bits 15 and 13 are stored as written; software keeps them 0
            if (hit(i_req, OFS_PRECHG)) prechg_d = i_req.wdata & WMASK_PRECHG;
            if (hit(i_req, OFS_DIAG)) diag_d = i_req.wdata & WMASK_DIAG;
            if (hit(i_req, OFS_STICHG)) stichg_d = i_req.wdata & WMASK_STICHG;
        end
        if (i_req.rd) begin
            if (hit(i_req, OFS_PRECHG)) rdata_d = prechg_q;
            else if (hit(i_req, OFS_DIAG)) rdata_d = diag_q & WMASK_DIAG;
            else if (hit(i_req, OFS_STICHG)) rdata_d = stichg_q & WMASK_STICHG;
            else rdata_d = 16'h0000;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            prechg_q <= RST_PRECHG;
            diag_q <= RST_DIAG;
            stichg_q <= RST_STICHG;
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            prechg_q <= prechg_d;
            diag_q <= diag_d;
            stichg_q <= stichg_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // one timer per channel and phase; duration from the live field
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_ch
            gdrv_phase_timer #(.STEP_CYC(TSTEP_CYC)) u_pc (
                .i_clk(i_clk),
                .i_rstn(i_rstn),
                .i_start(i_prechg_start[g]),
                .i_code(chan_code(prechg_q, g, 1'b0)),
                .o_busy(pc_busy[g]),
                .o_done(pc_done[g])
            );
            gdrv_phase_timer #(.STEP_CYC(TSTEP_CYC)) u_pd (
                .i_clk(i_clk),
                .i_rstn(i_rstn),
                .i_start(i_predchg_start[g]),
                .i_code(chan_code(prechg_q, g, 1'b1)),
                .o_busy(pd_busy[g]),
                .o_done(pd_done[g])
            );
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pc_act_q <= 3'h0;
            pd_act_q <= 3'h0;
        end else begin
            pc_act_q <= pc_busy;
            pd_act_q <= pd_busy;
        end
    end

    // decoded controls, each straight from a register
    assign o_rdata = rdata_q;
    assign o_rvalid = rvalid_q;
    assign o_prechg_active = pc_act_q;
    assign o_predchg_active = pd_act_q;
    assign o_pwm_precharge_timing = prechg_q;
    assign o_deep_adapt_en = prechg_q[POS_DEEP_AD];
    assign o_generator_detect_enable = prechg_q[POS_GEN_DET];
    assign o_sense_amp_side_select = diag_q[POS_CSA_SIDE];
    assign o_overcurrent_filter_time = diag_q[POS_OCFILT +: 2];
    assign o_sense_amp_disable = diag_q[POS_CSA_OFF];
    assign o_bridge_offstate_pulldown = diag_q[3:0];
    assign o_bridge_static_set_select = stichg_q[POS_STSEL +: 4];
    assign o_static_gate_current_set2 = stichg_q[POS_SET2 +: 4];
    assign o_static_gate_current_set1 = stichg_q[POS_SET1 +: 4];

    // filter count registered so the output stays flop-driven
    logic [16:0] ocf_q;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) ocf_q <= 17'(OCF_CYC0);
        else ocf_q <= ocf_cycles(diag_q[POS_OCFILT +: 2]);
    end
    assign o_oc_filter_cycles = ocf_q;

    // assertions
    logic [7:0] pc0_len_q;
    logic [1:0] pc0_code_q;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) pc0_len_q <= 8'h00;
        else if (pc_busy[0]) pc0_len_q <= pc0_len_q + 8'h01;
        else pc0_len_q <= 8'h00;
    end
    // code held from the accepted start, so a rewrite mid-phase cannot skew the check
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) pc0_code_q <= 2'h0;
        else if (i_prechg_start[0] && !pc_busy[0] && !pc_done[0]) pc0_code_q <= prechg_q[1:0];
    end

    reserved_diag_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_req.rd && i_req.addr == OFS_DIAG) |=> o_rdata[7:4] == 4'h0)
        else $error("reserved diag bits read nonzero");
    reserved_static_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_req.rd && !i_req.bank && i_req.addr == OFS_STICHG) |=> o_rdata[15:12] == 4'h0)
        else $error("reserved static bits read nonzero");
    bank_read_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_req.rd && i_req.bank && i_req.addr == OFS_STICHG) |=> o_rdata == 16'h0000)
        else $error("static select readable in bank one");
    static_codes_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_req.wr && !i_req.bank && i_req.addr == OFS_STICHG)
        |=> o_static_gate_current_set2 == $past(i_req.wdata[7:4])
        && o_static_gate_current_set1 == $past(i_req.wdata[3:0]))
        else $error("static current codes not updated");
    bank_gate_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_req.wr && i_req.bank && i_req.addr == OFS_STICHG) |=> $stable(stichg_q))
        else $error("static select written in bank one");
    stichg_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_req.wr && !i_req.bank && i_req.addr == OFS_STICHG)
        |=> o_bridge_static_set_select == $past(i_req.wdata[11:8]))
        else $error("static set select not updated");
    diag_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_req.wr && i_req.addr == OFS_DIAG)
        |=> o_bridge_offstate_pulldown == $past(i_req.wdata[3:0]))
        else $error("pulldown bits not updated");
    deep_gen_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_req.wr && i_req.addr == OFS_PRECHG) |=> o_deep_adapt_en == $past(i_req.wdata[14])
        && o_generator_detect_enable == $past(i_req.wdata[12]))
        else $error("enable bits not updated");
    csa_ctrl_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_req.wr && i_req.addr == OFS_DIAG) |=> o_sense_amp_disable == $past(i_req.wdata[8])
        && o_sense_amp_side_select == $past(i_req.wdata[14]))
        else $error("sense amp controls not updated");
    ocf_time_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        $stable(diag_q) && diag_q[11:10] == 2'b01 |=> o_oc_filter_cycles == 17'(OCF_CYC1))
        else $error("filter count wrong for 10 us");
    prechg_len_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        $fell(pc_busy[0]) |-> pc0_len_q == 8'(TSTEP_CYC << pc0_code_q))
        else $error("pre-charge length wrong");
    predchg_run_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_predchg_start[0] && !pd_busy[0] && !pd_done[0] && prechg_q[3:2] == 2'b00)
        |=> pd_busy[0] [*8] ##1 pd_busy[0] ##1 pd_busy[0] ##1 pd_busy[0]
        ##1 pd_busy[0] ##1 pd_busy[0] ##1 !pd_busy[0])
        else $error("pre-discharge 125 ns length wrong");
endmodule // gdrv_cfg_regs
`default_nettype wire

// ### gdrv_host.sv
`default_nettype none
// serial master stand-in: one request per call, always starts on a fresh edge
module gdrv_host
    import gdrv_cfg_pkg::*;
(
    // clock
    input wire logic i_clk,
    // register bus
    output var reg_req_t o_req,
    input wire logic [15:0] i_rdata,
    input wire logic i_rvalid
);
    timeunit 1ns;
    timeprecision 100ps;
    initial o_req = '0;
    task automatic access(input logic w, input logic b, input logic [4:0] a,
                          input logic [15:0] d, output logic [15:0] q, output logic ok);
        logic [15:0] x;
        x = (a == OFS_PRECHG) ? (d & 16'h5fff) : d;
        q = 16'h0000;
        @(posedge i_clk);
        #1;
        o_req = '{wr: w, rd: ~w, bank: b, addr: a, wdata: x};
        @(posedge i_clk);
        #1;
        o_req = '0;
        ok = w;
        for (int n = 0; n < 4 && !ok; n++) begin
            if (i_rvalid === 1'b1) begin
                q = i_rdata;
                ok = 1'b1;
            end else begin
                @(posedge i_clk);
                #1;
            end
        end
    endtask
endmodule // gdrv_host
`default_nettype wire

// ### gate_drive_timing_diag_config_regs_bench.sv
`default_nettype none
module gate_drive_timing_diag_config_regs_bench
    import gdrv_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [2:0] pc_start = 3'h0;
    logic [2:0] pd_start = 3'h0;
    reg_req_t req;
    logic [15:0] rdata, pre_q;
    logic rvalid, deep, gen, side, dis;
    logic [2:0] pc_act, pd_act;
    logic [1:0] oc_t;
    logic [16:0] oc_cyc;
    logic [3:0] pd_en, st_sel, set1, set2;
    int n_fail = 0;
    int n_compared = 0;
    always #5 i_clk = ~i_clk;
    gdrv_host host (.i_clk(i_clk), .o_req(req), .i_rdata(rdata), .i_rvalid(rvalid));
    gdrv_cfg_regs uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(req), .o_rdata(rdata),
        .o_rvalid(rvalid), .i_prechg_start(pc_start), .i_predchg_start(pd_start),
        .o_prechg_active(pc_act), .o_predchg_active(pd_act), .o_deep_adapt_en(deep),
        .o_generator_detect_enable(gen), .o_sense_amp_side_select(side),
        .o_overcurrent_filter_time(oc_t), .o_oc_filter_cycles(oc_cyc),
        .o_sense_amp_disable(dis), .o_bridge_offstate_pulldown(pd_en),
        .o_bridge_static_set_select(st_sel), .o_static_gate_current_set1(set1),
        .o_static_gate_current_set2(set2), .o_pwm_precharge_timing(pre_q));
    task automatic wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic b, input logic [4:0] a, input logic [15:0] d);
        logic [15:0] q;
        logic ok;
        host.access(1'b1, b, a, d, q, ok);
    endtask
    task automatic rd_chk(input logic b, input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] q;
        logic ok;
        host.access(1'b0, b, a, 16'h0000, q, ok);
        check(17'(ok), 17'h1);
        check(17'(q), 17'(exp));
        if (!ok) wrap_up();
    endtask
    task automatic reset_values;
        rd_chk(1'b0, OFS_PRECHG, 16'h0000);
        rd_chk(1'b0, OFS_DIAG, 16'hc000);
        rd_chk(1'b0, OFS_STICHG, 16'h0044);
        check(17'({deep, gen, side, dis}), 17'h00002);
        check(17'({pd_en, st_sel}), 17'h00000);
        check(17'({oc_t, set2, set1}), 17'h00044);
        check(oc_cyc, 17'h00258);
    endtask
    task automatic diag_fields;
        int cyc[4] = '{600, 1000, 5000, 10000};
        logic [15:0] d;
        for (int c = 0; c < 4; c++) begin
            d = {1'b1, 1'(c), 2'b00, 2'(c), 1'b0, 1'(c >> 1), 4'hf, 4'h1 << c};
            wr(1'b0, OFS_DIAG, d);
            rd_chk(1'b0, OFS_DIAG, d & 16'hff0f);
            check(17'({side, oc_t}), 17'({1'(c), 2'(c)}));
            check(17'({dis, pd_en}), 17'({1'(c >> 1), 4'h1 << c}));
            check(oc_cyc, 17'(cyc[c]));
        end
    endtask
    // field k: bit 2k of the register, even k pre-charge, odd k pre-discharge
    task automatic phase(input int k, input int exp);
        int cnt;
        int n;
        @(posedge i_clk);
        #1;
        if (k % 2 == 1) pd_start[k / 2] = 1'b1;
        else pc_start[k / 2] = 1'b1;
        @(posedge i_clk);
        #1;
        pc_start = 3'h0;
        pd_start = 3'h0;
        cnt = 0;
        for (n = 0; n < 300; n++) begin
            @(posedge i_clk);
            #1;
            if (((k % 2 == 1) ? pd_act[k / 2] : pc_act[k / 2]) === 1'b1) cnt++;
            else if (cnt > 0) break;
        end
        check(17'(cnt), 17'(exp));
        check(17'(n < 300), 17'h1);
        if (n == 300) wrap_up();
    endtask
    task automatic prechg_fields;
        logic [15:0] d;
        wr(1'b0, OFS_PRECHG, 16'hffff);
        rd_chk(1'b0, OFS_PRECHG, 16'h5fff);
        check(17'({deep, gen}), 17'h3);
        check(17'(pre_q), 17'h05fff);
        wr(1'b0, OFS_PRECHG, 16'h4000);
        check(17'({deep, gen}), 17'h2);
        for (int c = 0; c < 4; c++) begin
            d = 16'h0000;
            for (int k = 0; k < 6; k++) d[2 * k +: 2] = 2'((c + k) % 4);
            wr(1'b0, OFS_PRECHG, d);
            check(17'({deep, gen}), 17'h0);
            for (int k = 0; k < 6; k++) phase(k, 13 << ((c + k) % 4));
        end
    endtask
    task automatic static_bank;
        wr(1'b1, OFS_STICHG, 16'h0fff);
        rd_chk(1'b0, OFS_STICHG, 16'h0044);
        rd_chk(1'b1, OFS_STICHG, 16'h0000);
        wr(1'b0, OFS_STICHG, 16'hfa5c);
        rd_chk(1'b0, OFS_STICHG, 16'h0a5c);
        check(17'({st_sel, set2, set1}), 17'h00a5c);
        rd_chk(1'b0, 5'h1f, 16'h0000);
    endtask
    // reset asserted mid-run must clear written state at once
    task automatic mid_reset;
        @(posedge i_clk);
        #1;
        i_rstn = 1'b0;
        @(posedge i_clk);
        #1;
        check(17'({st_sel, set2, set1}), 17'h00044);
        i_rstn = 1'b1;
        reset_values();
    endtask
    initial begin
        repeat (5) @(posedge i_clk);
        #1;
        i_rstn = 1'b1;
        reset_values();
        diag_fields();
        prechg_fields();
        static_bank();
        mid_reset();
        wrap_up();
    end
endmodule // gate_drive_timing_diag_config_regs_bench
`default_nettype wire
